// ==== pmc_mode_ctl.sv ====
// power mode control: mode register, no-load register, accumulation, sign events
// assumes samples and enables are synchronous to clk; pulse output logic downstream
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_mode_ctl #(
  parameter int PWR_W = `PMC_PWR_W,
  parameter int ACC_W = `PMC_ACC_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire pmc_pkg::pmc_sfr_req_t    sfr_req,
  output logic [`PMC_DATA_W-1:0]        sfr_rdata,
  input  wire logic                     power_calc_enable,
  input  wire logic                     converter_enable,
  input  wire logic                     sample_valid,
  input  wire logic signed [PWR_W-1:0]  active_power,
  input  wire logic signed [PWR_W-1:0]  reactive_power,
  output logic signed [PWR_W:0]         active_delta,
  output logic signed [PWR_W:0]         reactive_delta,
  output logic                          delta_valid,
  output logic signed [ACC_W-1:0]       active_energy,
  output logic signed [ACC_W-1:0]       reactive_energy,
  output logic                          active_sign_irq,
  output logic                          reactive_sign_irq,
  output logic                          active_measure_off,
  output logic [`PMC_DATA_W-1:0]        no_load_control
);
  import pmc_pkg::*;

  localparam int DW = PWR_W + 1;

  // refused at elaboration: the sign extension and accumulator add need the margin
  if (PWR_W < 2 || ACC_W <= DW) begin : g_bad_widths
    $error("pmc_mode_ctl: PWR_W must be 2 or more and ACC_W wider than PWR_W+1");
  end

  typedef struct packed {
    pmc_ctl2_t                 ctl2;
    logic [`PMC_DATA_W-1:0]    no_load;
    logic [`PMC_DATA_W-1:0]    rdata;
    logic signed [DW-1:0]      act_delta;
    logic signed [DW-1:0]      rea_delta;
    logic                      delta_valid;
    logic signed [ACC_W-1:0]   act_acc;
    logic signed [ACC_W-1:0]   rea_acc;
    logic                      act_irq;
    logic                      rea_irq;
    logic                      act_neg;
    logic                      rea_neg;
    logic                      act_seen;
    logic                      rea_seen;
  } pmc_state_t;

  pmc_state_t    st_r;
  pmc_state_t    st_nxt;
  pmc_act_mode_t amode;
  pmc_rea_mode_t rmode;
  logic          run;
  logic          act_on;
  logic          take;
  logic          act_take;
  logic          a_neg;
  logic          r_neg;
  logic signed [DW-1:0] a_ext;
  logic signed [DW-1:0] r_ext;

  // ==========================================================================
  // mode decode
  always_comb begin
    run    = power_calc_enable && converter_enable;
    act_on = run && !st_r.ctl2.active_measure_off;
    take   = run && sample_valid;
    act_take = act_on && sample_valid;
    a_ext  = {active_power[PWR_W-1], active_power};
    r_ext  = {reactive_power[PWR_W-1], reactive_power};
    a_neg  = active_power[PWR_W-1];
    r_neg  = reactive_power[PWR_W-1];
    // magnitude bit wins over the other bit in both pairs
    if (st_r.ctl2.active_magnitude_accum) begin
      amode = PMC_AM_ABS;
    end else if (st_r.ctl2.active_positive_only) begin
      amode = PMC_AM_POS;
    end else begin
      amode = PMC_AM_SIGNED;
    end
    if (st_r.ctl2.reactive_magnitude_accum) begin
      rmode = PMC_RM_ABS;
    end else if (st_r.ctl2.reactive_follow_active_sign) begin
      rmode = PMC_RM_TAMPER;
    end else begin
      rmode = PMC_RM_SIGNED;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt             = st_r;
    st_nxt.delta_valid = 1'b0;
    st_nxt.act_irq     = 1'b0;
    st_nxt.rea_irq     = 1'b0;

    // register port; a read returns the value before a same-cycle write
    if (sfr_req.rd) begin
      if (sfr_req.addr == `PMC_CTL2_ADDR) begin
        st_nxt.rdata = st_r.ctl2;
      end else if (sfr_req.addr == `PMC_NLOAD_ADDR) begin
        st_nxt.rdata = st_r.no_load;
      end else begin
        st_nxt.rdata = `PMC_RDATA_IDLE;
      end
    end
    if (sfr_req.wr) begin
      if (sfr_req.addr == `PMC_CTL2_ADDR) begin
        // bit 6 kept at zero even if software breaks the convention
        st_nxt.ctl2 = sfr_req.wdata & `PMC_CTL2_WMASK;
      end else if (sfr_req.addr == `PMC_NLOAD_ADDR) begin
        st_nxt.no_load = sfr_req.wdata;
      end
    end

    if (take) begin
      st_nxt.delta_valid = 1'b1;
      // active contribution
      if (!act_take) begin
        st_nxt.act_delta = '0;
      end else begin
        case (amode)
          PMC_AM_ABS:    st_nxt.act_delta = a_neg ? -a_ext : a_ext;
          PMC_AM_POS:    st_nxt.act_delta = a_neg ? '0 : a_ext;
          default:       st_nxt.act_delta = a_ext;
        endcase
      end
      // reactive contribution
      case (rmode)
        PMC_RM_ABS:    st_nxt.rea_delta = r_neg ? -r_ext : r_ext;
        PMC_RM_TAMPER: st_nxt.rea_delta = a_neg ? -r_ext : r_ext;
        default:       st_nxt.rea_delta = r_ext;
      endcase
      st_nxt.act_acc = st_r.act_acc
                     + {{(ACC_W-DW){st_nxt.act_delta[DW-1]}}, st_nxt.act_delta};
      st_nxt.rea_acc = st_r.rea_acc
                     + {{(ACC_W-DW){st_nxt.rea_delta[DW-1]}}, st_nxt.rea_delta};
      // sign change events; first sample after a stop only sets the reference
      st_nxt.rea_irq  = st_r.rea_seen && (st_r.ctl2.reactive_edge_select
                        ? (st_r.rea_neg && !r_neg) : (!st_r.rea_neg && r_neg));
      st_nxt.rea_neg  = r_neg;
      st_nxt.rea_seen = 1'b1;
      if (act_on) begin
        st_nxt.act_irq  = st_r.act_seen && (st_r.ctl2.active_edge_select
                          ? (st_r.act_neg && !a_neg) : (!st_r.act_neg && a_neg));
        st_nxt.act_neg  = a_neg;
        st_nxt.act_seen = 1'b1;
      end
    end
    // a stopped unit forgets the previous sign so no stale event fires
    if (!run) begin
      st_nxt.rea_seen = 1'b0;
      st_nxt.act_seen = 1'b0;
    end
    if (!act_on) begin
      st_nxt.act_seen = 1'b0;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.ctl2    <= `PMC_CTL2_RESET;
      st_r.no_load <= `PMC_NLOAD_RESET;
      st_r.rdata   <= `PMC_RDATA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata          = st_r.rdata;
  assign active_delta       = st_r.act_delta;
  assign reactive_delta     = st_r.rea_delta;
  assign delta_valid        = st_r.delta_valid;
  assign active_energy      = st_r.act_acc;
  assign reactive_energy    = st_r.rea_acc;
  assign active_sign_irq    = st_r.act_irq;
  assign reactive_sign_irq  = st_r.rea_irq;
  assign active_measure_off = st_r.ctl2.active_measure_off;
  assign no_load_control    = st_r.no_load;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rea_pos;
    take && !r_neg;
  endsequence
  sequence s_rea_fall;
    take && r_neg && !st_r.ctl2.reactive_edge_select;
  endsequence
  sequence s_act_neg;
    act_take && a_neg;
  endsequence
  sequence s_act_rise;
    act_take && !a_neg && st_r.ctl2.active_edge_select;
  endsequence

  a_reset_ctl2_zero: assert property ($fell(rst) |-> st_r.ctl2 == '0)
    else $error("mode control register not zero after reset");
  a_reset_nload_zero: assert property ($fell(rst) |-> st_r.no_load == '0)
    else $error("no-load register not zero after reset");
  a_nload_write: assert property (sfr_req.wr && sfr_req.addr == `PMC_NLOAD_ADDR
    |=> no_load_control == $past(sfr_req.wdata))
    else $error("no-load register write lost");
  a_active_off_zero: assert property (take && st_r.ctl2.active_measure_off
    |=> delta_valid && active_delta == '0 && !active_sign_irq)
    else $error("active measurement ran while switched off");
  a_rea_fall_irq: assert property (s_rea_pos ##1 s_rea_fall
    |=> reactive_sign_irq)
    else $error("reactive falling sign event missed");
  a_act_rise_irq: assert property (s_act_neg ##1 s_act_rise
    |=> active_sign_irq)
    else $error("active rising sign event missed");
  a_irq_cause: assert property (active_sign_irq || reactive_sign_irq
    |-> $past(take) && $past(st_r.rea_seen || st_r.act_seen))
    else $error("sign event without a running sample");
  a_rea_abs_pos: assert property (take && st_r.ctl2.reactive_magnitude_accum
    |=> !reactive_delta[DW-1])
    else $error("reactive magnitude mode gave negative term");
  a_tamper_negate: assert property (take && rmode == PMC_RM_TAMPER && a_neg
    |=> reactive_delta == -$past(r_ext))
    else $error("reactive term not negated in tamper mode");
  a_act_abs_pos: assert property (act_take && st_r.ctl2.active_magnitude_accum
    |=> !active_delta[DW-1])
    else $error("active magnitude mode gave negative term");
  a_pos_only_drop: assert property (act_take && amode == PMC_AM_POS && a_neg
    |=> active_delta == '0 && active_energy == $past(st_r.act_acc))
    else $error("negative sample reached accumulator in positive mode");
  a_stopped_idle: assert property (!run |=> !delta_valid && !active_sign_irq
    && !reactive_sign_irq && $stable(active_energy) && $stable(reactive_energy))
    else $error("power calculation ran while disabled");
  a_bit6_zero: assert property (sfr_req.wr && sfr_req.addr == `PMC_CTL2_ADDR
    |=> !st_r.ctl2.reserved_zero)
    else $error("reserved bit of mode control register set");

endmodule // pmc_mode_ctl
`default_nettype wire

// ==== pmc_consts.svh ====
// register map, reset values and widths of the power mode control block
// assumes inclusion by its bare name from the package and the design file
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_ADDR_W      10
`define PMC_DATA_W      8
`define PMC_CTL2_ADDR   10'h181
`define PMC_NLOAD_ADDR  10'h182
`define PMC_CTL2_RESET  8'h00
`define PMC_NLOAD_RESET 8'h00
`define PMC_CTL2_WMASK  8'hBF
`define PMC_RDATA_IDLE  8'h00
`define PMC_PWR_W       24
`define PMC_ACC_W       40

`endif

// ==== pmc_pkg.sv ====
// types shared by the power mode control block and its users
// assumes pmc_consts.svh is on the include path
`default_nettype none

package pmc_pkg;
  `include "pmc_consts.svh"

  // field layout of the second mode control register, bit 7 first
  typedef struct packed {
    logic active_measure_off;
    logic reserved_zero;
    logic reactive_edge_select;
    logic active_edge_select;
    logic reactive_magnitude_accum;
    logic reactive_follow_active_sign;
    logic active_positive_only;
    logic active_magnitude_accum;
  } pmc_ctl2_t;

  // extended special-function-register access, one cycle per strobe
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`PMC_ADDR_W-1:0]   addr;
    logic [`PMC_DATA_W-1:0]   wdata;
  } pmc_sfr_req_t;

  typedef enum logic [1:0] {PMC_AM_SIGNED, PMC_AM_ABS, PMC_AM_POS} pmc_act_mode_t;
  typedef enum logic [1:0] {PMC_RM_SIGNED, PMC_RM_ABS, PMC_RM_TAMPER} pmc_rea_mode_t;
endpackage : pmc_pkg

`default_nettype wire

// ==== pmc_mode_ctl_tb.sv ====
// testbench for the power mode control block: register port, modes, sign events
// assumes pmc_pkg and pmc_mode_ctl compiled first, pmc_consts.svh on include path
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module testbench;
  import pmc_pkg::*;
  localparam int PW = 24;
  localparam int AW = 40;
  logic                 clk, rst, pce, cve, sv, dv, ai, ri, amo;
  pmc_sfr_req_t         req;
  logic signed [PW-1:0] ap, rp;
  logic [7:0]           rdata, nlc, cur;
  logic signed [PW:0]   ad, rd;
  logic signed [AW-1:0] ae, re, ea, er;
  logic [7:0]           ctls [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h80};
  int                   errors, checked;

  pmc_mode_ctl #(.PWR_W(PW), .ACC_W(AW)) pmc_mode_ctl_i (
    .clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .power_calc_enable(pce), .converter_enable(cve), .sample_valid(sv),
    .active_power(ap), .reactive_power(rp), .active_delta(ad), .reactive_delta(rd),
    .delta_valid(dv), .active_energy(ae), .reactive_energy(re),
    .active_sign_irq(ai), .reactive_sign_irq(ri),
    .active_measure_off(amo), .no_load_control(nlc));

  // ==========================================================
  // expectations and port tasks
  function automatic logic signed [PW:0] xa(logic [7:0] c, logic signed [PW-1:0] a);
    if (c[7]) return '0;
    if (c[0]) return (a < 0) ? -a : a;
    if (c[1]) return (a < 0) ? 0 : a;
    return a;
  endfunction

  function automatic logic signed [PW:0] xr(logic [7:0] c, logic signed [PW-1:0] a,
                                            logic signed [PW-1:0] r);
    if (c[3]) return (r < 0) ? -r : r;
    if (c[2] && a < 0) return -r;
    return r;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    if (a == `PMC_CTL2_ADDR) cur = d & `PMC_CTL2_WMASK;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    chk(rdata, exp);
  endtask

  // samples land with the edge after the strobe; outputs are read one step later
  task automatic samp(input logic signed [PW-1:0] a, input logic signed [PW-1:0] r,
                      input logic take);
    @(posedge clk);
    #1;
    sv = 1'b1;
    ap = a;
    rp = r;
    @(posedge clk);
    #1;
    sv = 1'b0;
    chk(dv, take);
    if (take) begin
      ea = ea + xa(cur, a);
      er = er + xr(cur, a, r);
    end
  endtask

  // two taken samples on consecutive edges, the tightest spacing the port allows
  task automatic samp2(input logic signed [PW-1:0] a0, input logic signed [PW-1:0] r0,
                       input logic signed [PW-1:0] a1, input logic signed [PW-1:0] r1);
    @(posedge clk);
    #1;
    sv = 1'b1;
    ap = a0;
    rp = r0;
    @(posedge clk);
    #1;
    ap = a1;
    rp = r1;
    ea = ea + xa(cur, a0);
    er = er + xr(cur, a0, r0);
    @(posedge clk);
    #1;
    sv = 1'b0;
    ea = ea + xa(cur, a1);
    er = er + xr(cur, a1, r1);
  endtask

  task automatic print_verdict;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {pce, cve, sv} = '0;
    ap = '0;
    rp = '0;
    req = '0;
    {ea, er, cur} = '0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({amo, nlc, dv, ai, ri}, '0);
    rchk(`PMC_CTL2_ADDR, `PMC_CTL2_RESET);
    rchk(`PMC_NLOAD_ADDR, `PMC_NLOAD_RESET);
    $display("test reset done");
    wr(`PMC_CTL2_ADDR, 8'hFF);
    chk(amo, 1'b1);
    rchk(`PMC_CTL2_ADDR, 8'hBF);
    wr(`PMC_NLOAD_ADDR, 8'h5A);
    chk(nlc, 8'h5A);
    rchk(`PMC_NLOAD_ADDR, 8'h5A);
    // unmapped space must neither read back nor alias onto the mode register
    wr(10'h183, 8'h77);
    rchk(10'h183, `PMC_RDATA_IDLE);
    rchk(`PMC_CTL2_ADDR, 8'hBF);
    wr(`PMC_CTL2_ADDR, 8'h00);
    chk(amo, 1'b0);
    $display("test registers done");
    {pce, cve} = 2'b11;
    foreach (ctls[i]) begin
      wr(`PMC_CTL2_ADDR, ctls[i]);
      for (int j = 0; j < 2; j++) begin
        samp(j ? 24'sd6 : -24'sd7, j ? -24'sd3 : 24'sd4, 1'b1);
        chk(ad, xa(cur, j ? 24'sd6 : -24'sd7));
        chk(rd, xr(cur, j ? 24'sd6 : -24'sd7, j ? -24'sd3 : 24'sd4));
        chk(ae, ea);
        chk(re, er);
      end
    end
    $display("test modes done");
    wr(`PMC_CTL2_ADDR, 8'h00);
    samp(24'sd1, 24'sd1, 1'b1);
    samp(-24'sd1, -24'sd1, 1'b1);
    chk({ai, ri}, 2'b11);
    samp(-24'sd2, -24'sd2, 1'b1);
    chk({ai, ri}, 2'b00);
    samp2(24'sd3, 24'sd3, -24'sd3, -24'sd3);
    chk({ai, ri}, 2'b11);
    chk(ae, ea);
    chk(re, er);
    wr(`PMC_CTL2_ADDR, 8'h30);
    samp(24'sd1, 24'sd1, 1'b1);
    chk({ai, ri}, 2'b11);
    samp2(-24'sd4, -24'sd4, 24'sd4, 24'sd4);
    chk({ai, ri}, 2'b11);
    chk(ae, ea);
    chk(re, er);
    $display("test sign events done");
    pce = 1'b0;
    samp(-24'sd1, -24'sd1, 1'b0);
    chk(ae, ea);
    pce = 1'b1;
    cve = 1'b0;
    samp(-24'sd1, -24'sd1, 1'b0);
    chk(re, er);
    cve = 1'b1;
    samp(-24'sd1, -24'sd1, 1'b1);
    chk({ai, ri}, 2'b00);
    samp(24'sd1, 24'sd1, 1'b1);
    chk({ai, ri}, 2'b11);
    chk(ae, ea);
    $display("test enables done");
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
